//--- rtl/aacq_consts.vh
`ifndef AACQ_CONSTS_VH
`define AACQ_CONSTS_VH
// io decode, primary and alternate bases
`define AACQ_ACTL_PRI      10'h1D8
`define AACQ_ACTL_ALT      10'h1E8
`define AACQ_RHI_PRI       10'h1D9
`define AACQ_RHI_ALT       10'h1E9
`define AACQ_IIOC_PRI      10'h1D3
`define AACQ_IIOC_ALT      10'h1E3
// analog control fields
`define AACQ_PWR_HI        7
`define AACQ_PWR_LO        6
`define AACQ_ACQ_BIT       5
`define AACQ_RNG_BIT       4
`define AACQ_BIP_BIT       3
`define AACQ_CH_HI         2
`define AACQ_CH_LO         0
// power/clock codes
`define AACQ_PWR_EXTCLK    2'h0
`define AACQ_PWR_INTCLK    2'h1
`define AACQ_PWR_STBY      2'h2
`define AACQ_PWR_FULL      2'h3
// industrial control: done bit and writable field
`define AACQ_DONE_BIT      7
`define AACQ_IIOC_RST      7'h00
// timing: acquisition 3260 ns, conversion 6000 ns, at 20 ns
`define AACQ_CLK_NS        20
`define AACQ_ACQ_NS        3260
`define AACQ_CONV_NS       6000
`define AACQ_ACQ_CYC       ((`AACQ_ACQ_NS + `AACQ_CLK_NS - 1) / `AACQ_CLK_NS)
`define AACQ_CONV_CYC      (`AACQ_CONV_NS / `AACQ_CLK_NS)
`define AACQ_CNT_W         9
`define AACQ_RES_W         12
`endif

//--- rtl/aacq_timer.v
`timescale 1ns/1ps
`include "aacq_consts.vh"
// down counter, load and count to expiry pulse
module aacq_timer
(
   input  wire                   clk,
   input  wire                   reset_n,
   input  wire                   load,
   input  wire [`AACQ_CNT_W-1:0] load_val,
   input  wire                   stop,
   output reg                    expired
);
   reg [`AACQ_CNT_W-1:0] cnt_r;
   reg                   run_r;

   // load wins over stop so a fresh start is never lost
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         cnt_r   <= {`AACQ_CNT_W{1'b0}};
         run_r   <= 1'b0;
         expired <= 1'b0;
      end
      else
      begin
         expired <= 1'b0;
         if (load)
         begin
            cnt_r <= load_val;
            run_r <= 1'b1;
         end
         else if (stop)
            run_r <= 1'b0;
         else if (run_r)
         begin
            if (cnt_r == {{(`AACQ_CNT_W-1){1'b0}}, 1'b1})
            begin
               run_r   <= 1'b0;
               expired <= 1'b1;
            end
            cnt_r <= cnt_r - {{(`AACQ_CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

//--- rtl/aacq_ctrl.v
`timescale 1ns/1ps
`include "aacq_consts.vh"
//  Function
// - analog control register written at 1D8h, or 1E8h when alternate base chosen.
// - top two bits select external clock, internal clock, standby or full power-down.
// - power-down codes keep the previously chosen clock source.
// - acquisition bit 0 write starts timed acquisition, then conversion automatically.
// - acquisition bit 1 write starts open-ended acquisition without conversion.
// - in open acquisition, a write with bit 0 ends it and starts conversion.
// - in open acquisition, a write with bit 1 restarts open acquisition.
// - power/clock field taken anew on the second external write.
// - range and polarity bits set the span for the conversion.
// - three low bits pick channel zero to seven in binary.
// - one of eight inputs converted into a twelve-bit result.
// - conversion finishes within six microseconds of its start.
// - completion may raise an interrupt request, enabled by configuration.
// - industrial control register read/write at 1D3h, or 1E3h alternate.
// - done bit clears on conversion start, result read or control write.
// - result low byte at 1D8h, high nibble at 1D9h, sign extended bipolar.
module aacq_ctrl
(
   input  wire                   clk,
   input  wire                   reset_n,
   input  wire                   alt_base,
   input  wire                   irq_enable,
   input  wire [9:0]             io_addr,
   input  wire                   io_wr,
   input  wire                   io_rd,
   input  wire [7:0]             io_wdata,
   input  wire [`AACQ_RES_W-1:0] conv_data,
   output reg  [7:0]             io_rdata,
   output reg                    sample_hold,
   output reg                    conv_busy,
   output reg  [2:0]             channel_select,
   output reg                    range_select_bit,
   output reg                    polarity_select_bit,
   output reg                    clock_internal,
   output reg                    standby_powerdown,
   output reg                    full_powerdown,
   output reg  [6:0]             iio_config,
   output reg                    conv_irq
);
   localparam ST_IDLE = 2'd0;
   localparam ST_TACQ = 2'd1;
   localparam ST_XACQ = 2'd2;
   localparam ST_CONV = 2'd3;

   // registered expiry adds one clock, so each load is one short of the count
   localparam integer           ACQ_LOAD_I  = `AACQ_ACQ_CYC - 1;
   localparam integer           CONV_LOAD_I = `AACQ_CONV_CYC - 1;
   localparam [`AACQ_CNT_W-1:0] ACQ_LOAD    = ACQ_LOAD_I[`AACQ_CNT_W-1:0];
   localparam [`AACQ_CNT_W-1:0] CONV_LOAD   = CONV_LOAD_I[`AACQ_CNT_W-1:0];

   reg  [1:0]             state_r;
   reg  [1:0]             state_nxt;
   reg                    done_r;
   reg  [`AACQ_RES_W-1:0] result_r;
   reg                    t_load;
   reg  [`AACQ_CNT_W-1:0] t_val;
   wire                   t_exp;
   wire                   hit_actl;
   wire                   hit_rhi;
   wire                   hit_iioc;
   wire                   ctl_wr;
   wire                   res_rd;
   wire                   acq_bit;
   wire                   conv_start;
   wire                   conv_end;
   wire                   iioc_wr;
   wire [1:0]             pwr_code;
   wire                   sign_fill;

   // address decode with selectable base
   // base select
   assign hit_actl = io_addr == (alt_base ? `AACQ_ACTL_ALT : `AACQ_ACTL_PRI);
   assign hit_rhi  = io_addr == (alt_base ? `AACQ_RHI_ALT : `AACQ_RHI_PRI);
   assign hit_iioc = io_addr == (alt_base ? `AACQ_IIOC_ALT : `AACQ_IIOC_PRI);
   assign ctl_wr   = io_wr && hit_actl;
   assign res_rd   = io_rd && (hit_actl || hit_rhi);
   assign acq_bit  = io_wdata[`AACQ_ACQ_BIT];
   assign conv_end = (state_r == ST_CONV) && t_exp;
   assign iioc_wr  = io_wr && hit_iioc;
   assign pwr_code = io_wdata[`AACQ_PWR_HI:`AACQ_PWR_LO];
   // sign fill follows the current polarity bit, not the one of the conversion
   assign sign_fill = polarity_select_bit & result_r[`AACQ_RES_W-1];

   // sequencer; a control write restarts the sequence, except a bit 0 write in open acquisition, which starts conversion
   // a write mid-conversion drops that result, so hosts poll done first
   always @*
   begin
      state_nxt = state_r;
      t_load    = 1'b0;
      t_val     = ACQ_LOAD;
      if (ctl_wr)
      begin
         if (state_r == ST_XACQ && !acq_bit)
         begin
            state_nxt = ST_CONV;
            t_load    = 1'b1;
            t_val     = CONV_LOAD;
         end
         else if (acq_bit)
            state_nxt = ST_XACQ;
         else
         begin
            state_nxt = ST_TACQ;
            t_load    = 1'b1;
         end
      end
      // only the timer moves the state without a host write
      else if (t_exp)
      begin
         case (state_r)
            ST_TACQ:
            begin
               state_nxt = ST_CONV;
               t_load    = 1'b1;
               t_val     = CONV_LOAD;
            end
            ST_CONV: state_nxt = ST_IDLE;
            default: state_nxt = state_r;
         endcase
      end
   end

   // a conversion load is told apart by its count
   assign conv_start = t_load && (t_val == CONV_LOAD);

   // stop on every control write so an open window leaves no stale expiry
   aacq_timer u_timer
   (
      .clk      (clk),
      .reset_n  (reset_n),
      .load     (t_load),
      .load_val (t_val),
      .stop     (ctl_wr),
      .expired  (t_exp)
   );

   // state, control fields, result and done
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         state_r             <= ST_IDLE;
         done_r              <= 1'b0;
         result_r            <= {`AACQ_RES_W{1'b0}};
         channel_select      <= 3'h0;
         range_select_bit    <= 1'b0;
         polarity_select_bit <= 1'b0;
         clock_internal      <= 1'b0;
         standby_powerdown   <= 1'b0;
         full_powerdown      <= 1'b0;
         iio_config          <= `AACQ_IIOC_RST;
      end
      else
      begin
         state_r <= state_nxt;
         if (ctl_wr)
         begin
            channel_select      <= io_wdata[`AACQ_CH_HI:`AACQ_CH_LO];
            range_select_bit    <= io_wdata[`AACQ_RNG_BIT];
            polarity_select_bit <= io_wdata[`AACQ_BIP_BIT];
            standby_powerdown <= pwr_code == `AACQ_PWR_STBY;
            full_powerdown    <= pwr_code == `AACQ_PWR_FULL;
            if (!io_wdata[`AACQ_PWR_HI])
               clock_internal <= io_wdata[`AACQ_PWR_LO];
         end
         // industrial control bits are only stored, nothing here uses them
         if (iioc_wr)
            iio_config <= io_wdata[6:0];
         if (conv_end)
            result_r <= conv_data;
         if (conv_end)
            done_r <= 1'b1;
         else if (ctl_wr || res_rd || conv_start)
            done_r <= 1'b0;
      end
   end

   // registered outputs and read data
   // sample_hold and conv_busy follow state_nxt so they line up with the state register
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         io_rdata    <= 8'h00;
         sample_hold <= 1'b0;
         conv_busy   <= 1'b0;
         conv_irq    <= 1'b0;
      end
      else
      begin
         // both acquisition kinds drive the same hold output
         sample_hold <= state_nxt == ST_TACQ || state_nxt == ST_XACQ;
         conv_busy   <= state_nxt == ST_CONV;
         conv_irq    <= irq_enable && (conv_end || (done_r && !ctl_wr && !res_rd));
         // unmapped reads return zero so a stray poll never sees done
         // register read mux
         if (io_rd && hit_actl)
            io_rdata <= result_r[7:0];
         else if (io_rd && hit_rhi)
            io_rdata <= {{4{sign_fill}}, result_r[11:8]};
         else if (io_rd && hit_iioc)
            io_rdata <= {done_r, iio_config};
         else
            io_rdata <= 8'h00;
      end
   end
endmodule

//--- testbench/aacq_conv_model.sv
`timescale 1ns/1ps
// converter stand-in with idle lines that churn
module aacq_conv_model
(
   input  wire        clk,
   input  wire        reset_n,
   input  wire [2:0]  channel_select,
   input  wire        conv_busy,
   output reg  [11:0] conv_data
);
   always @(posedge clk)
   begin
      if (!reset_n)
         conv_data <= 12'h5A5;
      else if (conv_busy)
         conv_data <= {channel_select, 9'h0A5};
      else
         conv_data <= ~conv_data;
   end
endmodule

//--- testbench/aacq_properties.sv
`timescale 1ns/1ps
`include "aacq_consts.vh"
module aacq_properties
(
   input wire       clk,
   input wire       reset_n,
   input wire       alt_base,
   input wire       irq_enable,
   input wire [9:0] io_addr,
   input wire       io_wr,
   input wire       io_rd,
   input wire [7:0] io_wdata,
   input wire       sample_hold,
   input wire       conv_busy,
   input wire       clock_internal,
   input wire       standby_powerdown,
   input wire       full_powerdown,
   input wire       conv_irq
);
   wire      hit = io_wr && io_addr == (alt_base ? `AACQ_ACTL_ALT : `AACQ_ACTL_PRI);
   reg [9:0] cnt_r;
   reg [1:0] mode_r;
   reg [7:0] wd_r;
   // cycles since last control write; mode 1 open, 2 bracketed
   always @(posedge clk)
   begin
      wd_r <= io_wdata;
      if (!reset_n)
      begin
         cnt_r  <= 10'h3FF;
         mode_r <= 2'h0;
      end
      else if (hit)
      begin
         cnt_r  <= 10'h001;
         mode_r <= io_wdata[5] ? 2'h1 : {sample_hold && mode_r == 2'h1, 1'b0};
      end
      else if (cnt_r != 10'h3FF)
         cnt_r <= cnt_r + 10'h001;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_acq; mode_r == 2'h0 && cnt_r >= 10'h001 && cnt_r <= 10'h0A3 |-> sample_hold && !conv_busy; endproperty
   a_acq: assert property (p_acq) else $error("timed acquisition");
   property p_conv; mode_r == 2'h0 && cnt_r >= 10'h0A4 && cnt_r <= 10'h1CF |-> conv_busy && !sample_hold; endproperty
   a_conv: assert property (p_conv) else $error("timed conversion");
   property p_end; mode_r[1] ? cnt_r == 10'h12D : cnt_r == 10'h1D0 |-> !conv_busy; endproperty
   a_end: assert property (p_end) else $error("conversion overrun");
   property p_ext; mode_r == 2'h2 && cnt_r <= 10'h12C |-> conv_busy && !sample_hold; endproperty
   a_ext: assert property (p_ext) else $error("bracketed conversion");
   property p_open; mode_r == 2'h1 && cnt_r != 10'h3FF |-> sample_hold && !conv_busy; endproperty
   a_open: assert property (p_open) else $error("open acquisition");
   property p_irq; mode_r == 2'h0 && cnt_r == 10'h1D1 |-> conv_irq == irq_enable; endproperty
   a_irq: assert property (p_irq) else $error("irq at completion");
   property p_hold; conv_irq && irq_enable && !io_wr && !io_rd ##1 irq_enable |-> conv_irq; endproperty
   a_hold: assert property (p_hold) else $error("irq dropped");
   property p_pwr; hit |=> standby_powerdown == (wd_r[7:6] == 2'h2) && full_powerdown == (wd_r[7:6] == 2'h3)
      && (wd_r[7] ? $stable(clock_internal) : clock_internal == wd_r[6]); endproperty
   a_pwr: assert property (p_pwr) else $error("power field");
   c_ext: cover property (mode_r == 2'h2 && cnt_r == 10'h12D);
   c_irq: cover property (conv_irq);
   c_restart: cover property (hit && io_wdata[5] && mode_r == 2'h1);
endmodule
bind aacq_ctrl aacq_properties i_props (.clk, .reset_n, .alt_base, .irq_enable, .io_addr, .io_wr, .io_rd,
   .io_wdata, .sample_hold, .conv_busy, .clock_internal, .standby_powerdown, .full_powerdown, .conv_irq);

//--- testbench/aacq_ctrl_test.sv
`timescale 1ns/1ps
module aacq_ctrl_test;
   reg         clk = 1'b0;
   reg         reset_n = 1'b0;
   reg         alt_base = 1'b0;
   reg         irq_enable = 1'b0;
   reg  [9:0]  io_addr = 10'h000;
   reg         io_wr = 1'b0;
   reg         io_rd = 1'b0;
   reg  [7:0]  io_wdata = 8'h00;
   reg  [7:0]  d;
   wire [11:0] conv_data;
   wire [7:0]  io_rdata;
   wire [6:0]  iio_config;
   wire [2:0]  channel_select;
   wire        sample_hold, conv_busy, range_select_bit, polarity_select_bit;
   wire        clock_internal, standby_powerdown, full_powerdown, conv_irq;
   integer     mismatches, cmp_count, i, k;
   aacq_ctrl i_dut (.clk, .reset_n, .alt_base, .irq_enable, .io_addr, .io_wr, .io_rd, .io_wdata, .conv_data,
      .io_rdata, .sample_hold, .conv_busy, .channel_select, .range_select_bit, .polarity_select_bit,
      .clock_internal, .standby_powerdown, .full_powerdown, .iio_config, .conv_irq);
   aacq_conv_model i_conv (.clk, .reset_n, .channel_select, .conv_busy, .conv_data);
   always #10 clk = ~clk;
   task chk(input [7:0] got, input [7:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   end
   endtask
   task end_sim;
   begin
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   // strobes held one cycle, results taken once settled
   task wr(input [9:0] a, input [7:0] v);
   begin
      @(posedge clk);
      io_addr <= a;
      io_wdata <= v;
      io_wr <= 1'b1;
      @(posedge clk);
      io_wr <= 1'b0;
      #1;
   end
   endtask
   task rd(input [9:0] a);
   begin
      @(posedge clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge clk);
      io_rd <= 1'b0;
      #1;
      d = io_rdata;
   end
   endtask
   // polled status, bounded so a stuck converter ends the run
   task wait_done(input [9:0] a);
   begin
      d = 8'h00;
      for (k = 0; k < 400 && !d[7]; k = k + 1)
         rd(a);
      if (!d[7])
      begin
         mismatches = mismatches + 1;
         end_sim;
      end
   end
   endtask
   initial
   begin
      mismatches = 0;
      cmp_count = 0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      rd(10'h1D3);
      chk(d, 8'h00);
      wr(10'h1D3, 8'h7F);
      chk({1'b0, iio_config}, 8'h7F);
      // every channel, span and both clock sources
      for (i = 0; i < 8; i = i + 1)
      begin
         @(posedge clk);
         irq_enable <= i[0];
         wr(10'h1D8, {1'b0, i[1], 1'b0, i[1:0], i[2:0]});
         chk({sample_hold, conv_busy, clock_internal, channel_select, range_select_bit, polarity_select_bit},
            {2'b10, i[1], i[2:0], i[1:0]});
         wait_done(10'h1D3);
         chk(d, 8'hFF);
         chk({7'h00, conv_irq}, {7'h00, i[0]});
         rd(10'h1D8);
         chk(d, 8'hA5);
         rd(10'h1D9);
         chk(d, {{4{i[2] & i[0]}}, i[2:0], 1'b0});
         rd(10'h1D3);
         chk(d, 8'h7F);
         chk({7'h00, conv_irq}, 8'h00);
      end
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(10'h1D8, {i[1:0], 6'h23});
         chk({5'h00, clock_internal, standby_powerdown, full_powerdown}, {5'h00, i != 0, i == 2, i == 3});
      end
      // restart the open window, then close it with same channel and a new clock source
      wr(10'h1D8, 8'h23);
      repeat (200) @(posedge clk);
      chk({6'h00, sample_hold, conv_busy}, 8'h02);
      wr(10'h1D8, 8'h43);
      chk({4'h0, conv_busy, sample_hold, clock_internal, full_powerdown}, 8'h0A);
      wait_done(10'h1D3);
      rd(10'h1D9);
      chk(d, 8'h06);
      @(posedge clk);
      alt_base <= 1'b1;
      wr(10'h1E8, 8'h1F);
      wait_done(10'h1E3);
      rd(10'h1D3);
      chk(d, 8'h00);
      rd(10'h1E9);
      chk(d, 8'hFE);
      end_sim;
   end
endmodule
